// File: rtl/hgc_counter.sv
/*
  line-sync gated counter: gate mode control, timed gate window,
  8-bit edge counter and status, reached by peripheral read and
  system register read/write strobes.
  assumes reset_n already combines power-on, clock-stop and enable-pin
  resets, and that access strobes are synchronous one-cycle pulses.
*/
// What this block does
// (R1) count sync rising edges only while gate open
// (R2) mode 00 closed, 01 free, 10 timed
// (R3) closed mode: generator stopped, no counting
// (R4) pin bias enabled only in open modes
// (R5) free mode: clear counter, open, count
// (R6) timed mode: clear, open, count within 8ms
// (R7) timed window lasts 1.69 ms then stops
// (R8) status flag shows gate open
// (R9) timed mode flag reads 1 immediately
// (R10) flag sits at status bit 3
// (R11) mode in bits 1:0 at 11H
// (R12) count readable at peripheral address 04H
// (R13) shared port bit reads zero when sync input
// (R14) software keeps control zero for port use
// (R15) resets force closed mode, clear counter
// (R16) synchronise input, detect edges from samples
// (R17) hold count after timed window closes
`timescale 1ns/10ps
`default_nettype none
`include "hgc_defines.svh"
module hgc_counter
  import hgc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // sync input pin and port bit
  input wire logic line_sync_input_pin,
  input wire logic shared_port_in,
  output logic shared_port_bit,
  output logic pin_bias_en,
  // system register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_rd,
  output logic [3:0] reg_rdata,
  // peripheral read into transfer buffer
  input wire logic [7:0] periph_addr,
  input wire logic peripheral_read_instr,
  output logic [7:0] transfer_buffer
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [1:0] mode_r, mode_nxt;
  hgc_state_t state_r, state_nxt;
  logic [`HGC_TMR_W-1:0] tmr_r, tmr_nxt;
  logic [7:0] count_r, count_nxt;
  logic [3:0] rdata_r, rdata_nxt;
  logic [7:0] tbuf_r, tbuf_nxt;
  logic port_r, port_nxt;
  logic bias_r, bias_nxt;
  logic port_m_r, port_s_r;
  logic rise;
  logic gate_open;
  logic ctrl_wr;

  hgc_edge_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin_in(line_sync_input_pin),
    .rise(rise)
  );

  function automatic logic [`HGC_TMR_W-1:0] cyc(input int unsigned n);
    cyc = n[`HGC_TMR_W-1:0];
  endfunction : cyc

  // reserved code 11 leaves the gate closed (but a write of 11 clears the counter), so only 01 and 10 open the pin
  function automatic logic mode_open(input logic [1:0] m);
    mode_open = (m == `HGC_MODE_FREE) || (m == `HGC_MODE_TIMED);
  endfunction : mode_open

  assign ctrl_wr = reg_wr && (reg_addr == `HGC_ADDR_CTRL);
  // flag is 1 during the start wait as well, not only in the window
  assign gate_open = (state_r != HGC_IDLE); // R8 R9

  // ------------------------------------------------------------
  // gate control
  // ------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    if (ctrl_wr) begin
      mode_nxt = reg_wdata[`HGC_MODE_HI:`HGC_MODE_LO]; // R11
      tmr_nxt = '0;
      unique case (reg_wdata[`HGC_MODE_HI:`HGC_MODE_LO]) // R2
        `HGC_MODE_FREE: state_nxt = HGC_FREE; // R5
        `HGC_MODE_TIMED: state_nxt = HGC_WAIT; // R6
        default: state_nxt = HGC_IDLE; // R3
      endcase
    end else begin
      unique case (state_r)
        HGC_IDLE: tmr_nxt = '0; // R3
        HGC_FREE: tmr_nxt = '0;
        HGC_WAIT: begin
          // the gate clock tick comes at most one period after the write
          if (tmr_r == cyc(`HGC_START_CYC) - cyc(1)) begin // R6
            tmr_nxt = '0;
            state_nxt = HGC_WIN;
          end else begin
            tmr_nxt = tmr_r + cyc(1);
          end
        end
        HGC_WIN: begin
          if (tmr_r == cyc(`HGC_WINDOW_CYC) - cyc(1)) begin // R7
            tmr_nxt = '0;
            state_nxt = HGC_IDLE;
          end else begin
            tmr_nxt = tmr_r + cyc(1);
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // counter and read paths
  // ------------------------------------------------------------
  always_comb begin
    count_nxt = count_r;
    if (ctrl_wr && (reg_wdata[`HGC_MODE_HI:`HGC_MODE_LO] != `HGC_MODE_CLOSED))
      count_nxt = `HGC_COUNT_RESET; // R5 R6
    else if (rise && (state_r == HGC_FREE || state_r == HGC_WIN))
      count_nxt = count_r + 8'h01; // R1 R17
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      rdata_nxt = 4'h0;
      if (reg_addr == `HGC_ADDR_CTRL)
        rdata_nxt = {2'h0, mode_r}; // R11
      else if (reg_addr == `HGC_ADDR_STATUS)
        rdata_nxt[`HGC_STAT_OPEN_BIT] = gate_open; // R10
    end
    tbuf_nxt = tbuf_r;
    if (peripheral_read_instr && periph_addr == `HGC_ADDR_COUNT)
      tbuf_nxt = count_r; // R12
    // pin in use as sync input whenever mode 01 or 10 is set
    port_nxt = mode_open(mode_r) ? 1'b0 : port_s_r; // R13
    bias_nxt = mode_open(mode_r); // R4
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= `HGC_MODE_CLOSED; // R15
      state_r <= HGC_IDLE;
      tmr_r <= '0;
      count_r <= `HGC_COUNT_RESET; // R15
      rdata_r <= 4'h0;
      tbuf_r <= 8'h00;
      port_r <= 1'b0;
      bias_r <= 1'b0;
      port_m_r <= 1'b0;
      port_s_r <= 1'b0;
    end else if (clk_en) begin
      mode_r <= mode_nxt;
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      count_r <= count_nxt;
      rdata_r <= rdata_nxt;
      tbuf_r <= tbuf_nxt;
      port_r <= port_nxt;
      bias_r <= bias_nxt;
      port_m_r <= shared_port_in;
      port_s_r <= port_m_r;
    end
  end

  assign reg_rdata = rdata_r;
  assign transfer_buffer = tbuf_r;
  assign shared_port_bit = port_r;
  assign pin_bias_en = bias_r;

endmodule : hgc_counter
`default_nettype wire

// File: rtl/hgc_defines.svh
/*
  constants for the line-sync gated counter: register addresses, field
  positions, reset values and gate timing counts.
  assumes a 40 MHz system clock.
*/
`ifndef HGC_DEFINES_SVH
`define HGC_DEFINES_SVH

// ------------------------------------------------------------
// register addresses (peripheral and system register spaces)
// ------------------------------------------------------------
`define HGC_ADDR_COUNT 8'h04
`define HGC_ADDR_CTRL 8'h11
`define HGC_ADDR_STATUS 8'h12

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define HGC_MODE_LO 0
`define HGC_MODE_HI 1
`define HGC_STAT_OPEN_BIT 3
`define HGC_CTRL_RESET 4'h0
`define HGC_COUNT_RESET 8'h00
`define HGC_MODE_CLOSED 2'h0
`define HGC_MODE_FREE 2'h1
`define HGC_MODE_TIMED 2'h2

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define HGC_CLK_HZ 40000000
`define HGC_WINDOW_US 1690
`define HGC_START_MAX_US 8000
// window length is a least time: 1690 us times 40 cycles per us, not rounded up
`define HGC_WINDOW_CYC ((`HGC_WINDOW_US * (`HGC_CLK_HZ / 1000000) + 0) )
// gate clock tick period; counting starts at the first tick after the write
`define HGC_START_CYC ((`HGC_START_MAX_US * (`HGC_CLK_HZ / 1000000)))
`define HGC_TMR_W 19

`endif

// File: rtl/hgc_edge_sync.sv
/*
  two-flop synchroniser plus rising-edge detector for the sync input pin.
  assumes the pin is asynchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module hgc_edge_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // pin in, edge out
  input wire logic pin_in,
  output logic rise
);
  logic meta_r, sync_r, prev_r;
  logic meta_nxt, sync_nxt, prev_nxt;

  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (clk_en) begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // edge taken only from the second stage onward
  assign rise = sync_r & ~prev_r; // R16
endmodule : hgc_edge_sync
`default_nettype wire

// File: rtl/hgc_pkg.sv
/*
  types shared by the line-sync gated counter.
  assumes hgc_defines.svh supplies the numbers.
*/
package hgc_pkg;
  typedef enum logic [1:0] {
    HGC_IDLE,
    HGC_FREE,
    HGC_WAIT,
    HGC_WIN
  } hgc_state_t;
endpackage : hgc_pkg

// File: test/hgc_counter_props.sv
/* checker for hgc_counter port timing.
   assumes one clock and one-cycle strobes. */
`timescale 1ns/10ps
`default_nettype none
module hgc_counter_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // register side
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [3:0] reg_rdata,
  // count and pins
  input wire logic peripheral_read_instr,
  input wire logic [7:0] transfer_buffer,
  input wire logic pin_bias_en,
  input wire logic shared_port_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic wctl;
  logic rdc;
  assign wctl = reg_wr && clk_en && reg_addr == 8'h11;
  assign rdc = reg_rd && clk_en;
  // bias is registered behind the mode, so it settles one cycle later
  chk_bias_open: assert property (wctl && reg_wdata[1:0] inside {2'h1, 2'h2} |=> ##1 pin_bias_en)
    else $error("bias off in open mode");
  chk_bias_closed: assert property (wctl && reg_wdata[1:0] inside {2'h0, 2'h3}
    |=> ##1 !pin_bias_en)
    else $error("bias on in closed mode");
  // port bit is registered behind the mode, so allow one extra cycle
  chk_port_zero: assert property (wctl && reg_wdata[1:0] == 2'h1 |=> ##1 !shared_port_bit)
    else $error("port bit not zero");
  chk_timed_flag: assert property (wctl && reg_wdata[1:0] == 2'h2 ##[1:2]
    rdc && reg_addr == 8'h12 |=> reg_rdata == 4'h8)
    else $error("gate flag not set in timed mode");
  chk_ctrl_upper: assert property (rdc && reg_addr == 8'h11 |=> reg_rdata[3:2] == 2'h0)
    else $error("control upper bits not zero");
  chk_unmapped_zero: assert property (rdc && !(reg_addr inside {8'h11, 8'h12})
    |=> reg_rdata == 4'h0)
    else $error("unmapped read not zero");
  chk_buf_hold: assert property (!(peripheral_read_instr && clk_en) |=> $stable(transfer_buffer))
    else $error("transfer buffer moved");
  chk_rdata_hold: assert property (!rdc |=> $stable(reg_rdata))
    else $error("read data moved");
  chk_reset_clear: assert property ($rose(reset_n) |-> !pin_bias_en
    && transfer_buffer == 8'h00 && reg_rdata == 4'h0)
    else $error("outputs not cleared by reset");
endmodule : hgc_counter_props
bind hgc_counter hgc_counter_props hgc_counter_props_i (.clk(clk), .reset_n(reset_n),
  .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .peripheral_read_instr(peripheral_read_instr),
  .transfer_buffer(transfer_buffer), .pin_bias_en(pin_bias_en),
  .shared_port_bit(shared_port_bit));
`default_nettype wire

// File: test/hgc_sync_src.sv
/* sync separator model: line pulses while en is high.
   assumes the pin is driven low between pulses. */
`timescale 1ns/10ps
`default_nettype none
module hgc_sync_src (
  // clock and control
  input wire logic clk,
  input wire logic en,
  // pin and rising edge tally
  output logic pin,
  output logic [7:0] edges
);
  logic [3:0] ph;
  logic lvl;
  initial begin ph = 4'h0; pin = 1'b0; edges = 8'h00; end
  // offset from the edge so the pin looks asynchronous to clk
  always @(posedge clk) begin
    #3;
    ph = (ph == 4'h9) ? 4'h0 : ph + 4'h1;
    lvl = en && ph < 4'h4;
    if (lvl && !pin) edges = edges + 8'h01;
    pin = lvl;
  end
endmodule : hgc_sync_src
`default_nettype wire

// File: test/tb_top.sv
/* bench for hgc_counter with a sync pulse source.
   assumes 40 MHz; the timed window is too long to run out here. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk, reset_n, clk_en, pin, port_in, wr, rd, prd, bias, port_bit, src_en;
  logic [7:0] addr, paddr, buf_q, edges, base, n1;
  logic [3:0] wdata, rdata;
  int bad_count, compares;
  // mode, status, bias, port bit
  logic [7:0] rows [4] = '{8'h01, 8'h62, 8'hA2, 8'hC1};
  hgc_sync_src hgc_sync_src_i (.clk(clk), .en(src_en), .pin(pin), .edges(edges));
  hgc_counter hgc_counter_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .line_sync_input_pin(pin), .shared_port_in(port_in), .shared_port_bit(port_bit),
    .pin_bias_en(bias), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
    .reg_rdata(rdata), .periph_addr(paddr), .peripheral_read_instr(prd),
    .transfer_buffer(buf_q));
  initial begin clk = 0; forever #12.5 clk = ~clk; end
  task close_out;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task reg_write(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask : reg_write
  task reg_check(input logic [7:0] a, input logic [3:0] e);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : reg_check
  task cnt_check(input logic [7:0] e);
    @(posedge clk) begin paddr <= 8'h04; prd <= 1'b1; end
    @(posedge clk) prd <= 1'b0;
    #1 `CHK(buf_q, e)
  endtask : cnt_check
  // trailing idle covers the sync and edge latency
  task run_src(input int n);
    @(posedge clk) src_en <= 1'b1;
    repeat (n) @(posedge clk);
    src_en <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : run_src
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out;
  end
  initial begin
    clk_en = 1; port_in = 1; reset_n = 0; wr = 0; rd = 0; prd = 0; src_en = 0;
    addr = 0; paddr = 0; wdata = 0; bad_count = 0; compares = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      reg_write(8'h11, {2'h0, rows[i][7:6]});
      reg_check(8'h12, rows[i][5:2]);
      `CHK(bias, rows[i][1])
      `CHK(port_bit, rows[i][0])
      if (rows[i][7:6] != 2'h3) reg_check(8'h11, {2'h0, rows[i][7:6]});
    end
    $display("mode table done");
    base = edges;
    reg_write(8'h11, 4'h1);
    run_src(60);
    n1 = edges - base;
    cnt_check(n1);
    reg_write(8'h11, 4'h0);
    run_src(40);
    cnt_check(n1);
    reg_write(8'h11, 4'h1);
    cnt_check(8'h00);
    base = edges;
    run_src(30);
    cnt_check(edges - base);
    $display("free count done");
    reg_write(8'h11, 4'h2);
    reg_check(8'h12, 4'h8);
    run_src(100);
    cnt_check(8'h00);
    $display("timed start done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    reg_check(8'h11, 4'h0);
    reg_check(8'h12, 4'h0);
    cnt_check(8'h00);
    `CHK(bias, 1'b0)
    reg_check(8'h13, 4'h0);
    $display("reset and unmapped done");
    close_out;
  end
endmodule : tb_top
`default_nettype wire
